// ---- cwtl_cfg.svh ----
// Constants for the current warning and overtemperature limit register block.
// Summary of operation
// R1: Command 46h sets averaged current warning level.
// R2: Warning bits 15:11 read-only exponent, zero, 1 A.
// R3: Warning bits 10:6 always read as zero; code returns the stack level in bits 8:0 on a broadcast read.
// R4: Warning bits 5:0 writable, restored at reset.
// R5: Written mantissa reads back unchanged; applied value binned.
// R6: Reset restores fixed code of a supported setting.
// R7: Read-only bit change: NACK, discard, set flags.
// R8: Warning bins: below 8 is 5 A, steps 5 A.
// R9: Broadcast write with phase FFh splits stack level.
// R10: Two phases: add 1, shift right one, bin.
// R11: Four phases: add 2, shift right two, bin.
// R12: Three phases: lookup table from stack level.
// R13: Broadcast read: only primary answers, secondaries silent.
// R14: Primary reports per-phase level times phase count.
// R15: Command 4Fh holds overtemperature fault limit, Celsius.
// R16: Digital comparator checks die temperature against limit.
// R17: Overtemperature exponent read-only 00010b, 4 C step.
// R18: Overtemperature mantissa binned from 115 to 150 C.
// R19: Overlapping three-phase bands: first ascending band wins; code gives the highest band reached.
// R20: Current at or above level sets sticky warning.
`ifndef CWTL_CFG_SVH
`define CWTL_CFG_SVH

`define CWTL_CMD_WARN        8'h46
`define CWTL_CMD_OT          8'h4F
`define CWTL_PHASE_ALL       8'hFF
`define CWTL_WARN_EXP        5'h00
`define CWTL_OT_EXP          5'h02
`define CWTL_EXP_MSB         15
`define CWTL_EXP_LSB         11
`define CWTL_MANT_MSB        5
`define CWTL_WARN_RST        6'h1E
`define CWTL_OT_RST          6'h22
`define CWTL_WARN_MIN_A      6'h05
`define CWTL_WARN_STEP_A     6'h05
`define CWTL_WARN_BANDS      10
`define CWTL_WARN_THR0       8
`define CWTL_TRI_THR0        23
`define CWTL_BAND_WIDTH      5
`define CWTL_TRI_BAND_WIDTH  15

`endif

// ---- cwtl_host_model.sv ----
// Host model that offers register requests on the link and collects the answers.
`timescale 1ns/1ns
module cwtl_host_model (
	input  wire logic                rst_b_i,
	output logic                     link_clk_o,
	output logic                     lk_valid_o,
	output cwtl_pkg::cwtl_req_s      lk_req_o,
	input  wire logic                lk_busy_i,
	input  wire logic                lk_done_i,
	input  wire cwtl_pkg::cwtl_rsp_s lk_rsp_i
);
	logic active = 1'b0;

	// The link clock runs only during reset and while a request is open.
	initial begin
		link_clk_o = 1'b0;
		lk_valid_o = 1'b0;
		lk_req_o = '0;
		#3;
		forever #16 link_clk_o = (active || !rst_b_i) ? ~link_clk_o : 1'b0;
	end

	task automatic xfer(input cwtl_pkg::cwtl_req_s req, output cwtl_pkg::cwtl_rsp_s rsp,
			output logic tout);
		int n;
		n = 0;
		active = 1'b1;
		// Busy is read at the falling edge, where it has settled, so the next rising edge takes.
		@(negedge link_clk_o);
		while (lk_busy_i !== 1'b0 && n < 40) begin
			@(negedge link_clk_o);
			n++;
		end
		lk_valid_o = 1'b1;
		lk_req_o = req;
		// Released request lines show the inverse so stale data is never mistaken.
		@(negedge link_clk_o);
		lk_valid_o = 1'b0;
		lk_req_o = ~req;
		while (lk_done_i !== 1'b1 && n < 40) begin
			@(posedge link_clk_o);
			#1;
			n++;
		end
		tout = (n >= 40);
		rsp = lk_rsp_i;
		repeat (2) @(posedge link_clk_o);
		active = 1'b0;
	endtask : xfer
endmodule : cwtl_host_model

// ---- cwtl_pkg.sv ----
// Types shared by the current warning and overtemperature limit block.
package cwtl_pkg;

	typedef struct packed {
		logic        wr;
		logic [7:0]  cmd;
		logic [7:0]  phase;
		logic [15:0] wdata;
	} cwtl_req_s;

	typedef struct packed {
		logic [15:0] rdata;
		logic        nack;
		logic        drive;
	} cwtl_rsp_s;

	typedef enum logic {
		CWTL_IDLE,
		CWTL_ANSWER
	} cwtl_core_e;

endpackage : cwtl_pkg

// ---- cwtl_regs.sv ----
// Current warning and overtemperature limit registers with link handshake.
`timescale 1ns/1ns
`include "cwtl_cfg.svh"

module cwtl_regs (
	input  wire logic                ref_clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                link_clk_i,
	input  wire logic                lk_valid_i,
	input  wire cwtl_pkg::cwtl_req_s lk_req_i,
	output logic                     lk_busy_o,
	output logic                     lk_done_o,
	output cwtl_pkg::cwtl_rsp_s      lk_rsp_o,
	input  wire logic [2:0]          phase_count_i,
	input  wire logic                primary_i,
	input  wire logic [7:0]          iout_avg_i,
	input  wire logic [7:0]          die_temp_i,
	input  wire logic                warn_clr_i,
	input  wire logic                status_clr_i,
	output logic [5:0]               warn_amps_o,
	output logic [7:0]               ot_limit_o,
	output logic                     oc_warn_o,
	output logic                     ot_fault_o,
	output logic                     comm_fault_o,
	output logic                     invalid_data_o
);

	// ------------------------------------------------------------
	// Binning functions
	// ------------------------------------------------------------
	function automatic logic [5:0] warn_bin(input logic [8:0] v);
		logic [5:0] amps;
		amps = `CWTL_WARN_MIN_A;
		for (int i = 0; i < `CWTL_WARN_BANDS; i++) begin
			if (int'(v) >= `CWTL_WARN_THR0 + `CWTL_BAND_WIDTH * i) begin
				amps = amps + `CWTL_WARN_STEP_A;
			end
		end
		return amps;
	endfunction : warn_bin

	// Bands are checked by their lower bound, so overlaps go to the highest current.
	function automatic logic [5:0] tri_bin(input logic [7:0] v);
		logic [5:0] amps;
		amps = `CWTL_WARN_MIN_A;
		for (int i = 0; i < `CWTL_WARN_BANDS; i++) begin
			if (int'(v) >= `CWTL_TRI_THR0 + `CWTL_TRI_BAND_WIDTH * i) begin
				amps = amps + `CWTL_WARN_STEP_A;
			end
		end
		return amps;
	endfunction : tri_bin

	function automatic logic [7:0] ot_bin(input logic [5:0] m);
		logic [7:0] c;
		c = 8'h96;
		if (m < 6'h1E) begin
			c = 8'h73;
		end else if (m == 6'h1E) begin
			c = 8'h78;
		end else if (m == 6'h1F) begin
			c = 8'h7D;
		end else if (m < 6'h22) begin
			c = 8'h82;
		end else if (m == 6'h22) begin
			c = 8'h87;
		end else if (m == 6'h23) begin
			c = 8'h8C;
		end else if (m == 6'h24) begin
			c = 8'h91;
		end
		return c;
	endfunction : ot_bin

	// ------------------------------------------------------------
	// Link domain: capture request, toggle to core, wait answer
	// ------------------------------------------------------------
	cwtl_pkg::cwtl_req_s lk_hold_ff;
	cwtl_pkg::cwtl_rsp_s lk_rsp_ff;
	logic                req_tgl_ff;
	logic                lk_busy_ff;
	logic                lk_done_ff;
	logic                ack_s1_ff;
	logic                ack_s2_ff;
	logic                ack_seen_ff;
	logic                ack_tgl_ff;
	cwtl_pkg::cwtl_rsp_s rsp_ff;

	wire lk_take = lk_valid_i && !lk_busy_ff;
	wire ack_evt = ack_s2_ff ^ ack_seen_ff;

	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lk_hold_ff <= '0;
			req_tgl_ff <= 1'b0;
		end else if (lk_take) begin
			lk_hold_ff <= lk_req_i;
			req_tgl_ff <= !req_tgl_ff;
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_s1_ff   <= 1'b0;
			ack_s2_ff   <= 1'b0;
			ack_seen_ff <= 1'b0;
		end else begin
			ack_s1_ff   <= ack_tgl_ff;
			ack_s2_ff   <= ack_s1_ff;
			ack_seen_ff <= ack_s2_ff;
		end
	end

	// The answer word is held by the core until the next request, so it is stable here.
	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lk_busy_ff <= 1'b0;
			lk_done_ff <= 1'b0;
			lk_rsp_ff  <= '0;
		end else begin
			lk_busy_ff <= lk_take || (lk_busy_ff && !ack_evt);
			lk_done_ff <= ack_evt;
			if (ack_evt) begin
				lk_rsp_ff <= rsp_ff;
			end
		end
	end

	// ------------------------------------------------------------
	// Core domain synchronisers
	// ------------------------------------------------------------
	logic       req_s1_ff;
	logic       req_s2_ff;
	logic       req_seen_ff;
	logic [2:0] pc_s1_ff;
	logic [2:0] pc_s2_ff;
	logic       prim_s1_ff;
	logic       prim_s2_ff;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			req_s1_ff   <= 1'b0;
			req_s2_ff   <= 1'b0;
			req_seen_ff <= 1'b0;
			pc_s1_ff    <= 3'h1;
			pc_s2_ff    <= 3'h1;
			prim_s1_ff  <= 1'b0;
			prim_s2_ff  <= 1'b0;
		end else begin
			req_s1_ff   <= req_tgl_ff;
			req_s2_ff   <= req_s1_ff;
			req_seen_ff <= req_s2_ff;
			pc_s1_ff    <= phase_count_i;
			pc_s2_ff    <= pc_s1_ff;
			prim_s1_ff  <= primary_i;
			prim_s2_ff  <= prim_s1_ff;
		end
	end

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	cwtl_pkg::cwtl_core_e state_ff;
	cwtl_pkg::cwtl_core_e nxt_state;
	logic [5:0]           warn_mant_ff;
	logic [5:0]           ot_mant_ff;
	logic [5:0]           warn_amps_ff;
	logic [7:0]           ot_c_ff;

	wire        req_evt  = req_s2_ff ^ req_seen_ff;
	wire        is_warn  = lk_hold_ff.cmd == `CWTL_CMD_WARN;
	wire        is_ot    = lk_hold_ff.cmd == `CWTL_CMD_OT;
	wire        bcast    = lk_hold_ff.phase == `CWTL_PHASE_ALL;
	wire [15:0] wd       = lk_hold_ff.wdata;
	wire        wr_warn  = lk_hold_ff.wr && is_warn;
	wire        wr_ot    = lk_hold_ff.wr && is_ot;
	wire        bad_warn = wr_warn && (bcast ? (wd[15:8] != 8'h00) : (wd[15:6] != 10'h000)); // see R7
	wire        bad_ot   = wr_ot && (wd[15:6] != {`CWTL_OT_EXP, 5'h00}); // see R7
	wire        ro_bad   = bad_warn || bad_ot;
	wire        unknown  = !is_warn && !is_ot;
	wire        do_warn  = req_evt && wr_warn && !bad_warn;
	wire        do_ot    = req_evt && wr_ot && !bad_ot;
	wire        bc_read  = !lk_hold_ff.wr && is_warn && bcast;

	// ------------------------------------------------------------
	// Phase split of a stack-wide warning level
	// ------------------------------------------------------------
	wire [8:0] lvl      = {1'b0, wd[7:0]};
	wire [8:0] lvl_half = 9'((lvl + 9'h001) >> 1); // see R10
	wire [8:0] lvl_qtr  = 9'((lvl + 9'h002) >> 2); // see R11
	wire [5:0] split_code =
		(pc_s2_ff == 3'h2) ? warn_bin(lvl_half) :  // see R10
		(pc_s2_ff == 3'h4) ? warn_bin(lvl_qtr) :   // see R11
		(pc_s2_ff == 3'h3) ? tri_bin(wd[7:0]) :    // see R12, see R19
		warn_bin(lvl);
	// A broadcast write stores the binned ampere figure; a direct write stores the mantissa as written.
	wire [5:0] nxt_warn_mant = !do_warn ? warn_mant_ff :
		bcast ? split_code : wd[`CWTL_MANT_MSB:0]; // see R9, see R5
	wire [5:0] nxt_ot_mant = do_ot ? wd[`CWTL_MANT_MSB:0] : ot_mant_ff; // see R15

	wire [8:0] stack_amps = {3'h0, warn_amps_ff} * {6'h00, pc_s2_ff}; // see R14
	wire [15:0] warn_word = {`CWTL_WARN_EXP, 5'h00, warn_mant_ff}; // see R2, see R3
	wire [15:0] ot_word   = {`CWTL_OT_EXP, 5'h00, ot_mant_ff}; // see R17
	wire [15:0] rd_word   = bc_read ? {7'h00, stack_amps} :
		is_warn ? warn_word : is_ot ? ot_word : 16'h0000;

	cwtl_pkg::cwtl_rsp_s nxt_rsp;
	assign nxt_rsp.rdata = lk_hold_ff.wr ? 16'h0000 : rd_word;
	assign nxt_rsp.nack  = unknown || ro_bad; // see R7
	assign nxt_rsp.drive = !(bc_read && !prim_s2_ff); // see R13

	assign nxt_state = (state_ff == cwtl_pkg::CWTL_IDLE && req_evt) ?
		cwtl_pkg::CWTL_ANSWER : cwtl_pkg::CWTL_IDLE;

	// ------------------------------------------------------------
	// Core registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			warn_mant_ff <= `CWTL_WARN_RST; // see R4, see R6
			ot_mant_ff   <= `CWTL_OT_RST;   // see R6
		end else begin
			warn_mant_ff <= nxt_warn_mant;
			ot_mant_ff   <= nxt_ot_mant;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff   <= cwtl_pkg::CWTL_IDLE;
			rsp_ff     <= '0;
			ack_tgl_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			case (state_ff)
				cwtl_pkg::CWTL_IDLE: begin
					if (req_evt) begin
						rsp_ff <= nxt_rsp;
					end
				end
				cwtl_pkg::CWTL_ANSWER: begin
					ack_tgl_ff <= !ack_tgl_ff;
				end
				default: begin
					ack_tgl_ff <= ack_tgl_ff;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Applied thresholds, comparators and status flags
	// ------------------------------------------------------------
	logic oc_warn_ff;
	logic ot_fault_ff;
	logic comm_fault_ff;
	logic inv_data_ff;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			warn_amps_ff  <= `CWTL_WARN_MIN_A;
			ot_c_ff       <= 8'h91;
			oc_warn_ff    <= 1'b0;
			ot_fault_ff   <= 1'b0;
			comm_fault_ff <= 1'b0;
			inv_data_ff   <= 1'b0;
		end else begin
			warn_amps_ff  <= warn_bin({3'h0, warn_mant_ff}); // see R8, see R1
			ot_c_ff       <= ot_bin(ot_mant_ff); // see R18
			oc_warn_ff    <= (iout_avg_i >= {2'h0, warn_amps_ff}) || (oc_warn_ff && !warn_clr_i); // see R20
			ot_fault_ff   <= die_temp_i >= ot_c_ff; // see R16
			comm_fault_ff <= (req_evt && ro_bad) || (comm_fault_ff && !status_clr_i); // see R7
			inv_data_ff   <= (req_evt && ro_bad) || (inv_data_ff && !status_clr_i); // see R7
		end
	end

	assign lk_busy_o      = lk_busy_ff;
	assign lk_done_o      = lk_done_ff;
	assign lk_rsp_o       = lk_rsp_ff;
	assign warn_amps_o    = warn_amps_ff;
	assign ot_limit_o     = ot_c_ff;
	assign oc_warn_o      = oc_warn_ff;
	assign ot_fault_o     = ot_fault_ff;
	assign comm_fault_o   = comm_fault_ff;
	assign invalid_data_o = inv_data_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	wire rd_warn = req_evt && !lk_hold_ff.wr && is_warn && !bcast;

	a_warn_ro_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see R3
		rd_warn |=> rsp_ff.rdata[15:6] == 10'h000)
		else $error("warning read shows nonzero read-only bits");

	a_mant_readback: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see R5
		(req_evt && wr_warn && !bcast && !bad_warn) |=> warn_mant_ff == $past(wd[5:0]))
		else $error("written warning mantissa not stored");

	a_bad_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see R7
		(req_evt && ro_bad) |=> rsp_ff.nack && comm_fault_ff && inv_data_ff
			&& warn_mant_ff == $past(warn_mant_ff) && ot_mant_ff == $past(ot_mant_ff))
		else $error("read-only write not refused");

	a_warn_top_bin: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see R8
		(warn_mant_ff >= 6'h35) ##1 (warn_mant_ff >= 6'h35) |-> warn_amps_ff == 6'h37)
		else $error("top warning band not 55 A");

	a_split_two: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see R10
		(do_warn && bcast && pc_s2_ff == 3'h2 && wd[7:0] <= 8'h0E) |=> warn_mant_ff == 6'h05)
		else $error("two-phase split wrong");

	a_split_four: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see R11
		(do_warn && bcast && pc_s2_ff == 3'h4 && wd[7:0] == 8'h1E) |=> warn_mant_ff == 6'h0A)
		else $error("four-phase split wrong");

	a_tri_table: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see R12
		(do_warn && bcast && pc_s2_ff == 3'h3 && wd[7:0] >= 8'h9F) |=> warn_mant_ff == 6'h37)
		else $error("three-phase table top wrong");

	a_secondary_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see R13
		(req_evt && bc_read && !prim_s2_ff) |=> !rsp_ff.drive)
		else $error("secondary answered broadcast read");

	a_stack_read: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see R14
		(req_evt && bc_read && prim_s2_ff) |=> rsp_ff.drive
			&& rsp_ff.rdata[8:0] == {3'h0, $past(warn_amps_ff)} * {6'h00, $past(pc_s2_ff)})
		else $error("stack read value wrong");

	a_ot_compare: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see R16
		(die_temp_i >= ot_c_ff) |=> ot_fault_ff)
		else $error("overtemperature not flagged");

	a_warn_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see R20
		(oc_warn_ff && !warn_clr_i) |=> oc_warn_ff)
		else $error("warning flag dropped without clear");

	a_done_pulse: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		lk_done_ff |=> !lk_done_ff && (lk_busy_ff == $past(lk_valid_i)))
		else $error("done not a single pulse");

	c_bcast_write: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		do_warn && bcast && pc_s2_ff == 3'h3);
	c_bad_write: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		req_evt && ro_bad);
	c_stack_read: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		req_evt && bc_read && prim_s2_ff);
	c_ot_fault: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(ot_fault_ff));

endmodule : cwtl_regs

// ---- testbench.sv ----
// Self-checking bench for the current warning and overtemperature limit registers.
`timescale 1ns/1ns
module testbench;
	logic                ref_clk_i = 1'b0;
	logic                rst_b_i = 1'b0;
	logic                link_clk;
	logic                lk_valid;
	cwtl_pkg::cwtl_req_s lk_req;
	logic                lk_busy;
	logic                lk_done;
	cwtl_pkg::cwtl_rsp_s lk_rsp;
	cwtl_pkg::cwtl_rsp_s rsp;
	logic [2:0]          phase_count_i = 3'h1;
	logic                primary_i = 1'b1;
	logic [7:0]          iout_avg_i = 8'h00;
	logic [7:0]          die_temp_i = 8'h00;
	logic                warn_clr_i = 1'b0;
	logic                status_clr_i = 1'b0;
	logic [5:0]          warn_amps;
	logic [7:0]          ot_limit;
	logic                oc_warn;
	logic                ot_fault;
	logic                comm_fault;
	logic                invalid_data;
	logic [31:0]         rnd = 32'hDA7C;
	logic [5:0]          m;
	logic [7:0]          lvl;
	int                  amps;
	int                  n_errors = 0;
	int                  samples_checked = 0;
	int                  cycles = 0;
	int                  corner[8] = '{0, 7, 8, 12, 13, 52, 53, 63};
	int                  stack[7] = '{14, 22, 23, 30, 157, 158, 159};

	cwtl_regs dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk),
		.lk_valid_i(lk_valid), .lk_req_i(lk_req), .lk_busy_o(lk_busy), .lk_done_o(lk_done),
		.lk_rsp_o(lk_rsp), .phase_count_i(phase_count_i), .primary_i(primary_i),
		.iout_avg_i(iout_avg_i), .die_temp_i(die_temp_i), .warn_clr_i(warn_clr_i),
		.status_clr_i(status_clr_i), .warn_amps_o(warn_amps), .ot_limit_o(ot_limit),
		.oc_warn_o(oc_warn), .ot_fault_o(ot_fault), .comm_fault_o(comm_fault),
		.invalid_data_o(invalid_data));

	cwtl_host_model host (.rst_b_i(rst_b_i), .link_clk_o(link_clk), .lk_valid_o(lk_valid),
		.lk_req_o(lk_req), .lk_busy_i(lk_busy), .lk_done_i(lk_done), .lk_rsp_i(lk_rsp));

	always #4 ref_clk_i = ~ref_clk_i;

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			$display("FAIL %0t timeout", $time);
			final_report();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic int warn_bin(input int v);
		if (v < 8) return 5;
		if (v >= 53) return 55;
		return 10 + 5 * ((v - 8) / 5);
	endfunction : warn_bin

	function automatic int ot_bin(input int v);
		if (v < 30) return 115;
		if (v < 32) return 120 + 5 * (v - 30);
		if (v < 34) return 130;
		if (v >= 37) return 150;
		return 135 + 5 * (v - 34);
	endfunction : ot_bin

	function automatic int split(input int l, input int pc);
		if (pc == 2) return warn_bin((l + 1) >> 1);
		if (pc == 4) return warn_bin((l + 2) >> 2);
		if (pc != 3) return warn_bin(l);
		if (l < 23) return 5;
		if (l >= 158) return 55;
		return 10 + 5 * ((l - 23) / 15);
	endfunction : split

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check_val

	task automatic access(input logic wr, input logic [7:0] cmd, input logic [7:0] ph,
			input logic [15:0] wd);
		logic tout;
		host.xfer(cwtl_pkg::cwtl_req_s'({wr, cmd, ph, wd}), rsp, tout);
		if (tout) begin
			n_errors++;
			$display("FAIL %0t no answer", $time);
		end
		repeat (2) @(negedge ref_clk_i);
	endtask : access

	task automatic pulse(ref logic sig);
		@(negedge ref_clk_i);
		sig = 1'b1;
		@(negedge ref_clk_i);
		sig = 1'b0;
		repeat (2) @(negedge ref_clk_i);
	endtask : pulse

	task automatic bad_write(input logic [7:0] cmd, input logic [15:0] wd, input logic [15:0] keep);
		access(1'b1, cmd, 8'h00, wd);
		check_val(16'(rsp.nack), 16'h0001, "bad write nack");
		check_val(16'({comm_fault, invalid_data}), 16'h0003, "fault flags");
		access(1'b0, cmd, 8'h00, 16'h0000);
		check_val(rsp.rdata, keep, "value kept");
		pulse(status_clr_i);
		check_val(16'({comm_fault, invalid_data}), 16'h0000, "flags cleared");
	endtask : bad_write

	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (3) @(negedge ref_clk_i);
		rst_b_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		access(1'b0, 8'h46, 8'h00, 16'h0000);
		check_val(rsp.rdata, 16'h001E, "warn reset word");
		check_val(16'(warn_amps), 16'h001E, "warn reset level");
		access(1'b0, 8'h4F, 8'h00, 16'h0000);
		check_val(rsp.rdata, 16'h1022, "ot reset word");
		check_val(16'(ot_limit), 16'h0087, "ot reset limit");
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			m = (i < 8) ? 6'(corner[i]) : rnd[5:0];
			rnd = lfsr(rnd);
			access(1'b1, 8'h46, 8'h00, {10'h000, m});
			check_val(16'(rsp.nack), 16'h0000, "write nack");
			access(1'b0, 8'h46, 8'h00, 16'h0000);
			check_val(rsp.rdata, {10'h000, m}, "warn readback");
			check_val(16'(warn_amps), 16'(warn_bin(int'(m))), "warn level");
		end
		$display("test warn write done");
		bad_write(8'h46, {10'h001, m}, {10'h000, m});
		bad_write(8'h46, 16'h8005, {10'h000, m});
		access(1'b1, 8'h47, 8'h00, 16'h0000);
		check_val(16'({rsp.nack, comm_fault, invalid_data}), 16'h0004, "unknown command");
		for (int i = 0; i < 14; i++) begin
			m = (i < 9) ? 6'(29 + i) : rnd[5:0];
			rnd = lfsr(rnd);
			access(1'b1, 8'h4F, 8'h00, {10'h040, m});
			check_val(16'(rsp.nack), 16'h0000, "ot write nack");
			access(1'b0, 8'h4F, 8'h00, 16'h0000);
			check_val(rsp.rdata, {10'h040, m}, "ot readback");
			check_val(16'(ot_limit), 16'(ot_bin(int'(m))), "ot limit");
		end
		bad_write(8'h4F, {10'h000, m}, {10'h040, m});
		$display("test ot and refusal done");
		for (int pc = 1; pc < 5; pc++) begin
			@(negedge ref_clk_i);
			phase_count_i = 3'(pc);
			repeat (4) @(negedge ref_clk_i);
			for (int i = 0; i < 10; i++) begin
				lvl = (i < 7) ? 8'(stack[i]) : rnd[7:0];
				rnd = lfsr(rnd);
				amps = split(int'(lvl), pc);
				access(1'b1, 8'h46, 8'hFF, {8'h00, lvl});
				check_val(16'(warn_amps), 16'(amps), "split level");
				access(1'b0, 8'h46, 8'h00, 16'h0000);
				check_val(rsp.rdata, 16'(amps), "split code");
				access(1'b0, 8'h46, 8'hFF, 16'h0000);
				check_val(16'(rsp.drive), 16'h0001, "primary drives");
				check_val(16'(rsp.rdata[8:0]), 16'(amps * pc), "stack read");
			end
		end
		primary_i = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		access(1'b0, 8'h46, 8'hFF, 16'h0000);
		check_val(16'(rsp.drive), 16'h0000, "secondary silent");
		$display("test broadcast done");
		iout_avg_i = 8'(amps - 1);
		die_temp_i = 8'(ot_bin(int'(m)));
		pulse(warn_clr_i);
		check_val(16'({oc_warn, ot_fault}), 16'h0001, "below warn, at fault");
		iout_avg_i = 8'(amps);
		die_temp_i = 8'(ot_bin(int'(m)) - 1);
		repeat (2) @(negedge ref_clk_i);
		check_val(16'({oc_warn, ot_fault}), 16'h0002, "at warn, below fault");
		iout_avg_i = 8'h00;
		repeat (2) @(negedge ref_clk_i);
		check_val(16'(oc_warn), 16'h0001, "warn sticky");
		pulse(warn_clr_i);
		check_val(16'(oc_warn), 16'h0000, "warn cleared");
		$display("test flags done");
		final_report();
	end
endmodule : testbench
